// *** common/seq_pkg.sv ***
// Purpose: shared constants and types for the clock, power and reset sequencer
// Assumes: apb with 32-bit data, 100 MHz pclk
// Notes: offsets are byte addresses of aligned words
package seq_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_PCE = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h0C;
	localparam logic [7:0] OFF_IRQ_EN = 8'h10;
	localparam logic [7:0] OFF_MODE = 8'h14;
	// control register field positions
	localparam int CTL_WAIT_DIS = 0;
	localparam int CTL_STOP_DIS = 1;
	localparam int CTL_WAIT_LOCK = 2;
	localparam int CTL_STOP_LOCK = 3;
	localparam int CTL_SW_RESET = 4;
	// status event positions
	localparam int EV_WAKE = 0;
	localparam int EV_STOP_EXIT = 1;
	localparam int EV_WDOG_RST = 2;
	localparam int EV_SW_RST = 3;
	localparam int NUM_EVENTS = 4;
	// reset values
	localparam int NUM_PERIPH = 17;
	localparam logic [16:0] PCE_RESET = 17'h1FFFF;
	localparam logic [4:0] CONTROL_RESET = 5'h00;
	localparam logic [3:0] IRQ_EN_RESET = 4'h0;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int POR_EXTEND_CYCLES = 2097152;
	localparam int WINDOW_CYCLES = 32;
	localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
	// power modes
	typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_STOP} pmode_t;
	// reset sequence phases
	typedef enum logic [2:0] {PH_EXTEND, PH_CLOCKS, PH_PERIPH, PH_CORE, PH_DONE} rphase_t;
	// clock gate bundle toward the chip
	typedef struct packed {
		logic core_clk_en;
		logic periph_clk_en;
		logic [16:0] periph_gate;
	} clk_gate_t;
	// reset release bundle
	typedef struct packed {
		logic seq_rst_n;
		logic periph_rst_n;
		logic core_rst_n;
	} rst_out_t;
	// security interlocks
	typedef struct packed {
		logic block_ext_pspace;
		logic ext_boot_eff;
		logic debug_enable;
	} sec_out_t;
endpackage : seq_pkg

// *** hdl/clock_power_reset_sequencer.sv ***
// Purpose: clock division, power modes, reset sequencing and security interlocks
// Assumes: pclk is the master clock; async inputs pass two flops first
// Notes: gated clock outputs are expressed as enables, applied by clock gate cells
`timescale 1ns/1ps
module clock_power_reset_sequencer #(
	parameter int POR_CYCLES = seq_pkg::POR_EXTEND_CYCLES,
	parameter int WIN_CYCLES = seq_pkg::WINDOW_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_n,
	input wire logic ext_reset_n,
	input wire logic wdog_reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic stop_insn,
	input wire logic wait_insn,
	input wire logic [16:0] periph_irq,
	input wire logic [16:0] periph_irq_mask,
	input wire logic can_activity,
	input wire logic nonclocked_irq,
	input wire logic [15:0] security_bytes,
	input wire logic ext_boot_pin,
	output seq_pkg::clk_gate_t clk_gate,
	output logic half_clk,
	output seq_pkg::rst_out_t rst_out,
	output seq_pkg::sec_out_t sec_out,
	output seq_pkg::pmode_t power_mode,
	output logic irq
);
	localparam int CW = $clog2(POR_CYCLES + 1);

	////////////////////////////////////////////////////////////////////////
	// asynchronous reset merge and synchronisers
	logic ext_s1_ff, ext_s2_ff;
	logic can_s1_ff, can_s2_ff, nci_s1_ff, nci_s2_ff;
	logic [1:0] boot_sync_ff;
	wire async_rst_n = presetn & por_n & ext_reset_n;
	// release synchroniser: presetn, por_n or ext_reset_n clear it at once, release shows two edges later
	always_ff @(posedge pclk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			ext_s1_ff <= 1'b0;
			ext_s2_ff <= 1'b0;
		end else begin
			ext_s1_ff <= 1'b1;
			ext_s2_ff <= ext_s1_ff;
		end
	end
	// wake sources and boot pin from outside the clock domain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			can_s1_ff <= 1'b0;
			can_s2_ff <= 1'b0;
			nci_s1_ff <= 1'b0;
			nci_s2_ff <= 1'b0;
			boot_sync_ff <= 2'h0;
		end else begin
			can_s1_ff <= can_activity;
			can_s2_ff <= can_s1_ff;
			nci_s1_ff <= nonclocked_irq;
			nci_s2_ff <= nci_s1_ff;
			boot_sync_ff <= {boot_sync_ff[0], ext_boot_pin};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset sequencer
	seq_pkg::rphase_t phase_ff, nxt_phase;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic por_seen_ff;
	logic sync_rst;
	logic sw_rst_req;
	assign sync_rst = wdog_reset | sw_rst_req;
	wire cnt_last_ext = (cnt_ff == CW'(POR_CYCLES - 1));
	wire cnt_last_win = (cnt_ff == CW'(WIN_CYCLES - 1));
	// phase progression, each window counted out in full
	always_comb begin
		nxt_phase = phase_ff;
		nxt_cnt = cnt_ff + CW'(1);
		case (phase_ff)
			seq_pkg::PH_EXTEND: if (!por_seen_ff || cnt_last_ext) begin
				nxt_phase = seq_pkg::PH_CLOCKS;
				nxt_cnt = '0;
			end
			seq_pkg::PH_CLOCKS: if (cnt_last_win) begin
				nxt_phase = seq_pkg::PH_PERIPH;
				nxt_cnt = '0;
			end
			seq_pkg::PH_PERIPH: if (cnt_last_win) begin
				nxt_phase = seq_pkg::PH_CORE;
				nxt_cnt = '0;
			end
			seq_pkg::PH_CORE: if (cnt_last_win) begin
				nxt_phase = seq_pkg::PH_DONE;
				nxt_cnt = '0;
			end
			seq_pkg::PH_DONE: nxt_cnt = '0;
			default: begin
				nxt_phase = seq_pkg::PH_EXTEND;
				nxt_cnt = '0;
			end
		endcase
		if (sync_rst) begin
			nxt_phase = seq_pkg::PH_CLOCKS;
			nxt_cnt = '0;
		end
		// hold the sequence until reset release has passed both synchroniser stages
		if (!ext_s2_ff) begin
			nxt_phase = phase_ff;
			nxt_cnt = cnt_ff;
		end
	end
	// por_seen marks a reset caused by power-on; cleared once extension ends
	always_ff @(posedge pclk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			phase_ff <= seq_pkg::PH_EXTEND;
			cnt_ff <= '0;
		end else begin
			phase_ff <= nxt_phase;
			cnt_ff <= nxt_cnt;
		end
	end
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			por_seen_ff <= 1'b1;
		end else if (phase_ff != seq_pkg::PH_EXTEND) begin
			por_seen_ff <= 1'b0;
		end
	end
	// release outputs from flops so they release only on pclk edges; async reset clears them at once
	always_ff @(posedge pclk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			rst_out <= '0;
		end else begin
			rst_out.seq_rst_n <= (nxt_phase != seq_pkg::PH_EXTEND);
			rst_out.periph_rst_n <= (nxt_phase != seq_pkg::PH_EXTEND) && (nxt_phase != seq_pkg::PH_CLOCKS);
			rst_out.core_rst_n <= (nxt_phase == seq_pkg::PH_DONE);
		end
	end
	wire run_ok = (phase_ff == seq_pkg::PH_DONE);

	////////////////////////////////////////////////////////////////////////
	// security capture at release of peripheral reset
	logic secure_ff, ext_boot_ff;
	always_ff @(posedge pclk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			secure_ff <= 1'b1;
			ext_boot_ff <= 1'b0;
		end else if (phase_ff == seq_pkg::PH_PERIPH && cnt_ff == '0) begin
			secure_ff <= (security_bytes != 16'hFFFF);
			ext_boot_ff <= boot_sync_ff[1];
		end
	end
	// interlocks: no external code, no external boot, no debug
	assign sec_out.block_ext_pspace = secure_ff;
	assign sec_out.ext_boot_eff = ext_boot_ff & ~secure_ff;
	assign sec_out.debug_enable = ~secure_ff;

	////////////////////////////////////////////////////////////////////////
	// apb slave and registers
	logic [4:0] ctl_ff;
	logic [16:0] pce_ff;
	logic [3:0] status_ff, irq_en_ff;
	wire wr_acc = psel & penable & pwrite;
	wire hit_ctl = (paddr == seq_pkg::OFF_CONTROL);
	wire hit_pce = (paddr == seq_pkg::OFF_PCE);
	wire hit_sts = (paddr == seq_pkg::OFF_STATUS);
	wire hit_clr = (paddr == seq_pkg::OFF_IRQ_CLR);
	wire hit_en = (paddr == seq_pkg::OFF_IRQ_EN);
	wire hit_mode = (paddr == seq_pkg::OFF_MODE);
	wire mapped = hit_ctl | hit_pce | hit_sts | hit_clr | hit_en | hit_mode;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign sw_rst_req = wr_acc & hit_ctl & pwdata[seq_pkg::CTL_SW_RESET];
	// lock bits only set by software; they clear only on reset
	always_ff @(posedge pclk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			ctl_ff <= seq_pkg::CONTROL_RESET;
			pce_ff <= seq_pkg::PCE_RESET;
			irq_en_ff <= seq_pkg::IRQ_EN_RESET;
		end else begin
			if (wr_acc && hit_ctl) begin
				ctl_ff[seq_pkg::CTL_WAIT_DIS] <= pwdata[seq_pkg::CTL_WAIT_DIS] | ctl_ff[seq_pkg::CTL_WAIT_LOCK];
				ctl_ff[seq_pkg::CTL_STOP_DIS] <= pwdata[seq_pkg::CTL_STOP_DIS] | ctl_ff[seq_pkg::CTL_STOP_LOCK];
				ctl_ff[seq_pkg::CTL_WAIT_LOCK] <= pwdata[seq_pkg::CTL_WAIT_LOCK] | ctl_ff[seq_pkg::CTL_WAIT_LOCK];
				ctl_ff[seq_pkg::CTL_STOP_LOCK] <= pwdata[seq_pkg::CTL_STOP_LOCK] | ctl_ff[seq_pkg::CTL_STOP_LOCK];
			end
			if (wr_acc && hit_pce) begin
				pce_ff <= pwdata[16:0];
			end
			if (wr_acc && hit_en) begin
				irq_en_ff <= pwdata[3:0];
			end
			if (sync_rst) begin
				ctl_ff <= seq_pkg::CONTROL_RESET;
			end
		end
	end
	wire wait_dis = ctl_ff[seq_pkg::CTL_WAIT_DIS] | ctl_ff[seq_pkg::CTL_WAIT_LOCK];
	wire stop_dis = ctl_ff[seq_pkg::CTL_STOP_DIS] | ctl_ff[seq_pkg::CTL_STOP_LOCK];

	////////////////////////////////////////////////////////////////////////
	// power mode machine
	seq_pkg::pmode_t mode_ff, nxt_mode;
	wire [16:0] live_irq = periph_irq & ~periph_irq_mask;
	wire wake_wait = |live_irq;
	wire wake_stop = can_s2_ff | nci_s2_ff;
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			seq_pkg::MODE_RUN: begin
				if (run_ok && stop_insn && !stop_dis) begin
					nxt_mode = seq_pkg::MODE_STOP;
				end else if (run_ok && wait_insn && !wait_dis) begin
					nxt_mode = seq_pkg::MODE_WAIT;
				end
			end
			seq_pkg::MODE_WAIT: if (wake_wait) begin
				nxt_mode = seq_pkg::MODE_RUN;
			end
			seq_pkg::MODE_STOP: if (wake_stop) begin
				nxt_mode = seq_pkg::MODE_RUN;
			end
			default: nxt_mode = seq_pkg::MODE_RUN;
		endcase
	end
	// resets end stop mode through the async reset and the sync sources
	always_ff @(posedge pclk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			mode_ff <= seq_pkg::MODE_RUN;
		end else if (sync_rst) begin
			mode_ff <= seq_pkg::MODE_RUN;
		end else begin
			mode_ff <= nxt_mode;
		end
	end
	assign power_mode = mode_ff;

	////////////////////////////////////////////////////////////////////////
	// clock division and gate enables
	logic half_ff;
	always_ff @(posedge pclk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			half_ff <= 1'b0;
		end else begin
			half_ff <= ~half_ff;
		end
	end
	assign half_clk = half_ff;
	// enables change on the rising pclk edge except when async reset clears them, so a latch-type gate gives no glitch
	always_ff @(posedge pclk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			clk_gate <= '0;
		end else begin
			clk_gate.core_clk_en <= rst_out.seq_rst_n && (nxt_mode == seq_pkg::MODE_RUN);
			clk_gate.periph_clk_en <= rst_out.seq_rst_n && (nxt_mode != seq_pkg::MODE_STOP);
			clk_gate.periph_gate <= pce_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky events and interrupt
	logic [3:0] ev;
	assign ev[seq_pkg::EV_WAKE] = (mode_ff == seq_pkg::MODE_WAIT) && (nxt_mode == seq_pkg::MODE_RUN);
	assign ev[seq_pkg::EV_STOP_EXIT] = (mode_ff == seq_pkg::MODE_STOP) && (nxt_mode == seq_pkg::MODE_RUN);
	assign ev[seq_pkg::EV_WDOG_RST] = wdog_reset;
	assign ev[seq_pkg::EV_SW_RST] = sw_rst_req;
	wire [3:0] clr = (wr_acc && hit_clr) ? pwdata[3:0] : 4'h0;
	// set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			status_ff <= 4'h0;
		end else begin
			status_ff <= (status_ff & ~clr) | ev;
		end
	end
	assign irq = |(status_ff & irq_en_ff);

	////////////////////////////////////////////////////////////////////////
	// read mux
	always_comb begin
		prdata = seq_pkg::UNMAPPED_DATA;
		if (hit_ctl) prdata = {27'h0, ctl_ff};
		if (hit_pce) prdata = {15'h0, pce_ff};
		if (hit_sts) prdata = {28'h0, status_ff};
		if (hit_en) prdata = {28'h0, irq_en_ff};
		if (hit_mode) prdata = {24'h0, 3'(phase_ff), secure_ff, 2'h0, 2'(mode_ff)};
	end

	////////////////////////////////////////////////////////////////////////
	// assertions
	property p_wait_gates_core;
		@(posedge pclk) disable iff (!presetn)
		(mode_ff == seq_pkg::MODE_WAIT) |-> !clk_gate.core_clk_en && clk_gate.periph_clk_en;
	endproperty
	a_wait_gates_core: assert property (p_wait_gates_core) else $error("core clock on in wait");
	property p_wait_wake;
		@(posedge pclk) disable iff (!presetn)
		(mode_ff == seq_pkg::MODE_WAIT && wake_wait && !sync_rst) |=> mode_ff == seq_pkg::MODE_RUN ##0 clk_gate.core_clk_en;
	endproperty
	a_wait_wake: assert property (p_wait_wake) else $error("wait not left on interrupt");
	property p_stop_hold;
		@(posedge pclk) disable iff (!async_rst_n)
		(mode_ff == seq_pkg::MODE_STOP && !wake_stop && !sync_rst) |=> mode_ff == seq_pkg::MODE_STOP;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stop left without cause");
	property p_disabled_insn;
		@(posedge pclk) disable iff (!presetn)
		(mode_ff == seq_pkg::MODE_RUN && stop_dis && wait_dis) |=> mode_ff == seq_pkg::MODE_RUN;
	endproperty
	a_disabled_insn: assert property (p_disabled_insn) else $error("disabled instruction slept");
	property p_lock_sticks;
		@(posedge pclk) disable iff (!presetn || !async_rst_n)
		ctl_ff[seq_pkg::CTL_STOP_LOCK] && !sync_rst |=> ctl_ff[seq_pkg::CTL_STOP_LOCK];
	endproperty
	a_lock_sticks: assert property (p_lock_sticks) else $error("lock cleared without reset");
	property p_window_len;
		@(posedge pclk) disable iff (!async_rst_n || sync_rst)
		$rose(phase_ff == seq_pkg::PH_CORE) |-> (phase_ff == seq_pkg::PH_CORE) [*8];
	endproperty
	a_window_len: assert property (p_window_len) else $error("core window too short");
	property p_core_after_periph;
		@(posedge pclk) disable iff (!presetn)
		rst_out.core_rst_n |-> rst_out.periph_rst_n && rst_out.seq_rst_n;
	endproperty
	a_core_after_periph: assert property (p_core_after_periph) else $error("release order broken");
	property p_secure_debug;
		@(posedge pclk) disable iff (!presetn)
		secure_ff |-> !sec_out.debug_enable && !sec_out.ext_boot_eff && sec_out.block_ext_pspace;
	endproperty
	a_secure_debug: assert property (p_secure_debug) else $error("secure interlock open");
	property p_half_rate;
		@(posedge pclk) disable iff (!presetn)
		half_clk |=> !half_clk;
	endproperty
	a_half_rate: assert property (p_half_rate) else $error("half clock not toggling");
	property p_half_rise;
		@(posedge pclk) disable iff (!async_rst_n)
		ext_s2_ff && !half_clk |=> half_clk;
	endproperty
	a_half_rise: assert property (p_half_rise) else $error("half clock stuck low");
	property p_periph_release;
		@(posedge pclk) disable iff (!async_rst_n)
		(phase_ff == seq_pkg::PH_PERIPH) |-> rst_out.periph_rst_n;
	endproperty
	a_periph_release: assert property (p_periph_release) else $error("peripherals held in second window");
	property p_sticky_set;
		@(posedge pclk) disable iff (!presetn)
		ev[seq_pkg::EV_WAKE] |=> status_ff[seq_pkg::EV_WAKE];
	endproperty
	a_sticky_set: assert property (p_sticky_set) else $error("event lost");
endmodule : clock_power_reset_sequencer

// *** verif/core_model.sv ***
// Purpose: behavioural stand-in for the core and the peripherals beside the sequencer
// Assumes: bench requests one instruction per pulse of cmd
// Notes: cmd 1 = wait instruction, 2 = stop instruction
`timescale 1ns/1ps
module core_model (
	input wire logic pclk,
	input wire logic core_rst_n,
	input wire logic [1:0] cmd,
	input wire logic [16:0] raise,
	output logic stop_insn,
	output logic wait_insn,
	output logic [16:0] periph_irq
);
	////////////////////////////////////////////////////////////////
	// no pll is modelled: clocks come from the bench, software does any pll shutdown itself
	// instructions only issue while the core is out of reset
	always_ff @(posedge pclk) begin
		stop_insn <= core_rst_n & (cmd == 2'h2);
		wait_insn <= core_rst_n & (cmd == 2'h1);
		periph_irq <= raise;
	end
endmodule : core_model

// *** verif/test_clock_power_reset_sequencer.sv ***
// Purpose: self-checking bench for the clock, power and reset sequencer
// Assumes: short power-on extension and windows for run time
// Notes: results are queued by the driver and compared by a monitor
`timescale 1ns/1ps
module test_clock_power_reset_sequencer;
	localparam int POR = 16;
	localparam int WIN = 8;
	logic pclk = 0, presetn = 0, por_n = 0, ext_reset_n = 1, wdog_reset = 0;
	logic psel = 0, penable = 0, pwrite = 0, can_activity = 0, nonclocked_irq = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic pready, pslverr, half_clk, irq, stop_insn, wait_insn, err, h0;
	logic [1:0] cmd = 2'h0;
	logic [15:0] sec_bytes = 16'h5A5A;
	logic [16:0] raise = 17'h00000, periph_irq_mask = 17'h1FFFF, periph_irq, pv;
	seq_pkg::clk_gate_t clk_gate;
	seq_pkg::rst_out_t rst_out;
	seq_pkg::sec_out_t sec_out;
	seq_pkg::pmode_t power_mode;
	int bad_count = 0, num_checks = 0, n;
	string nm_q[$];
	logic [31:0] got_q[$], exp_q[$];
	always #5 pclk = ~pclk;
	clock_power_reset_sequencer #(.POR_CYCLES(POR), .WIN_CYCLES(WIN)) dut (.pclk(pclk), .presetn(presetn),
		.por_n(por_n), .ext_reset_n(ext_reset_n), .wdog_reset(wdog_reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.stop_insn(stop_insn), .wait_insn(wait_insn), .periph_irq(periph_irq), .periph_irq_mask(periph_irq_mask),
		.can_activity(can_activity), .nonclocked_irq(nonclocked_irq), .security_bytes(sec_bytes),
		.ext_boot_pin(1'b1), .clk_gate(clk_gate), .half_clk(half_clk), .rst_out(rst_out), .sec_out(sec_out),
		.power_mode(power_mode), .irq(irq));
	core_model partner (.pclk(pclk), .core_rst_n(rst_out.core_rst_n), .cmd(cmd), .raise(raise),
		.stop_insn(stop_insn), .wait_insn(wait_insn), .periph_irq(periph_irq));
	////////////////////////////////////////////////////////////////
	// compare, queue and verdict
	task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task note(input string nm, input logic [31:0] got, input logic [31:0] exp);
		nm_q.push_back(nm);
		got_q.push_back(got);
		exp_q.push_back(exp);
	endtask : note
	always @(negedge pclk) while (got_q.size() > 0) check(nm_q.pop_front(), got_q.pop_front(), exp_q.pop_front());
	task finish_test;
		while (got_q.size() > 0) check(nm_q.pop_front(), got_q.pop_front(), exp_q.pop_front());
		if (bad_count == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : finish_test
	task timeout;
		bad_count++;
		finish_test();
	endtask : timeout
	////////////////////////////////////////////////////////////////
	// apb transfer, waits until pready is sampled high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			i++;
		end while (!(pready === 1'b1) && i < 50);
		if (i >= 50) timeout();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wait_core(input logic lvl);
		n = 0;
		while (rst_out.core_rst_n !== lvl && n < 300) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 300) timeout();
	endtask : wait_core
	task wait_mode(input seq_pkg::pmode_t m);
		int i;
		i = 0;
		while (power_mode !== m && i < 40) begin
			@(posedge pclk);
			i++;
		end
		if (i >= 40) timeout();
	endtask : wait_mode
	task insn(input logic [1:0] c);
		@(posedge pclk);
		cmd <= c;
		@(posedge pclk);
		cmd <= 2'h0;
	endtask : insn
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(93));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		wait_core(1'b1);
		note("por_hold", 32'(n >= POR + 3 * WIN && n <= POR + 3 * WIN + 4), 32'h1);
		note("rst_order", 32'(rst_out), 32'h7);
		apb(1'b0, seq_pkg::OFF_PCE, 32'h0);
		note("pce_reset", rd, 32'h0001FFFF);
		apb(1'b0, seq_pkg::OFF_IRQ_EN, 32'h0);
		note("irq_en_reset", rd, 32'h0);
		note("security", 32'(sec_out), 32'h4);
		@(negedge pclk);
		h0 = half_clk;
		@(negedge pclk);
		note("half_clk", 32'(half_clk), 32'(!h0));
		pv = 17'($urandom);
		apb(1'b1, seq_pkg::OFF_PCE, {15'h0, pv});
		apb(1'b0, seq_pkg::OFF_PCE, 32'h0);
		note("pce_rd", rd, {15'h0, pv});
		note("pce_gate", 32'(clk_gate.periph_gate), 32'(pv));
		note("run_clks", {clk_gate.core_clk_en, clk_gate.periph_clk_en}, 32'h3);
		apb(1'b1, seq_pkg::OFF_IRQ_EN, 32'h1 << seq_pkg::EV_WAKE);
		insn(2'h1);
		wait_mode(seq_pkg::MODE_WAIT);
		note("wait_clks", {clk_gate.core_clk_en, clk_gate.periph_clk_en}, 32'h1);
		raise <= 17'h1 << ($urandom % 17);
		repeat (6) @(posedge pclk);
		note("masked", 32'(power_mode), 32'(seq_pkg::MODE_WAIT));
		periph_irq_mask <= 17'h00000;
		wait_mode(seq_pkg::MODE_RUN);
		note("wake_core", 32'(clk_gate.core_clk_en), 32'h1);
		raise <= 17'h00000;
		note("irq_up", 32'(irq), 32'h1);
		apb(1'b1, seq_pkg::OFF_IRQ_CLR, 32'hF);
		apb(1'b0, seq_pkg::OFF_STATUS, 32'h0);
		note("status_clr", rd, 32'h0);
		note("irq_down", 32'(irq), 32'h0);
		for (int s = 0; s < 2; s++) begin
			insn(2'h2);
			wait_mode(seq_pkg::MODE_STOP);
			raise <= 17'h00001;
			repeat (6) @(posedge pclk);
			note("stop_hold", 32'(power_mode), 32'(seq_pkg::MODE_STOP));
			raise <= 17'h00000;
			if (s == 0) can_activity <= 1'b1;
			else nonclocked_irq <= 1'b1;
			wait_mode(seq_pkg::MODE_RUN);
			can_activity <= 1'b0;
			nonclocked_irq <= 1'b0;
		end
		apb(1'b1, seq_pkg::OFF_CONTROL, 32'hF);
		for (int c = 1; c < 3; c++) begin
			insn(2'(c));
			repeat (6) @(posedge pclk);
			note("disabled", 32'(power_mode), 32'(seq_pkg::MODE_RUN));
		end
		apb(1'b0, 8'hFC, 32'h0);
		note("unmapped", {err, rd[30:0]}, 32'h80000000);
		apb(1'b1, seq_pkg::OFF_IRQ_CLR, 32'hF);
		for (int k = 0; k < 2; k++) begin
			if (k == 0) begin
				@(posedge pclk);
				wdog_reset <= 1'b1;
				@(posedge pclk);
				wdog_reset <= 1'b0;
			end else apb(1'b1, seq_pkg::OFF_CONTROL, 32'h1 << seq_pkg::CTL_SW_RESET);
			wait_core(1'b0);
			wait_core(1'b1);
			apb(1'b0, seq_pkg::OFF_STATUS, 32'h0);
			note("sync_rst", 32'(rd[seq_pkg::EV_WDOG_RST + k]), 32'h1);
			apb(1'b0, seq_pkg::OFF_CONTROL, 32'h0);
			note("lock_sync", rd, 32'h0);
		end
		apb(1'b1, seq_pkg::OFF_CONTROL, 32'hC);
		@(posedge pclk);
		ext_reset_n <= 1'b0;
		sec_bytes <= 16'hFFFF;
		repeat (3) @(posedge pclk);
		note("ext_rst", 32'(rst_out), 32'h0);
		ext_reset_n <= 1'b1;
		wait_core(1'b1);
		note("unsecured", 32'(sec_out), 32'h3);
		apb(1'b0, seq_pkg::OFF_CONTROL, 32'h0);
		note("lock_cleared", rd, 32'h0);
		insn(2'h1);
		wait_mode(seq_pkg::MODE_WAIT);
		finish_test();
	end
endmodule : test_clock_power_reset_sequencer
